// File: pkg/i2cp_pkg.sv
package i2cp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_HOLD   = 0;
  localparam int CTRL_FSEL   = 1;
  localparam int CTRL_TEN    = 3;
  localparam int CTRL_TXIE   = 4;
  localparam int CTRL_RXIE   = 5;
  localparam int ADDR_DIR    = 10;
  localparam int CMD_START   = 0;
  localparam int CMD_STOP    = 1;
  localparam int CMD_READ    = 2;
  localparam int CMD_NACK    = 3;
  localparam int ST_NACK     = 0;
  localparam int ST_STA_SEEN = 1;
  localparam int ST_STP_SEEN = 2;
  localparam int ST_BUSY     = 4;
  localparam int ST_ACTIVE   = 5;
  localparam int ST_FULL     = 7;
  localparam int ST_TXIFG    = 8;
  localparam int ST_RXIFG    = 9;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic       HOLD_RST   = 1'b1;
  localparam logic [1:0] FSEL_RST   = 2'b00;
  localparam logic [1:0] FSEL_TWO   = 2'b11;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int SCL_HALF_NS  = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;

  // Engine states.
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_STA   = 4'h1,
    S_RS_LO = 4'h2,
    S_RS_HI = 4'h3,
    S_B_LO  = 4'h4,
    S_B_HI  = 4'h5,
    S_WAIT  = 4'h6,
    S_P_LO  = 4'h7,
    S_P_HI  = 4'h8,
    S_P_END = 4'h9
  } i2cp_state_t;

endpackage : i2cp_pkg

// File: pkg/i2cp_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
// Byte stream between the register side and the transmit buffer.
interface i2cp_fifo_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fill (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface : i2cp_fifo_if
`default_nettype wire

// File: core/i2cp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module i2cp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic   clk,
  input wire logic   rst_b,
  // Stream ports.
  i2cp_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic [AW:0]  used;
  wire          do_wr = f.wr_valid & f.wr_ready;
  wire          do_rd = f.rd_valid & f.rd_ready;

  // Full and empty come from the pointer distance, so both are exact.
  assign used       = wp_r - rp_r;
  assign f.wr_ready = (used != (AW + 1)'(DEPTH));
  assign f.rd_valid = (used != '0);
  assign f.rd_data  = mem_r[rp_r[AW-1:0]];

  // Pointer update.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
    end
  end

  // Storage carries no reset; pointers guard it.
  always_ff @(posedge clk) begin
    if (do_wr) mem_r[wp_r[AW-1:0]] <= f.wr_data;
  end
endmodule : i2cp_fifo
`default_nettype wire

// File: core/i2cp_core.sv
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module i2cp_core
  import i2cp_pkg::*;
#(
  parameter int HALF_CYC   = SCL_HALF_CYC,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // Wishbone slave.
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  // Two-wire bus pins.
  input  wire logic        SCL_I,
  output var  logic        SCL_O,
  output var  logic        SCL_OE,
  input  wire logic        SDA_I,
  output var  logic        SDA_O,
  output var  logic        SDA_OE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Expands byte selects into a bit mask.
  function automatic logic [31:0] sel_mask(input logic [3:0] s);
    sel_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : sel_mask

  // First address byte for either address width.
  function automatic logic [7:0] first_byte(input logic ten, input logic [10:0] a);
    if (ten) first_byte = {TEN_PREFIX, a[9:8], a[ADDR_DIR]};
    else     first_byte = {a[6:0], a[ADDR_DIR]};
  endfunction : first_byte

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        hold_r;
  logic [1:0]  fsel_r;
  logic        ten_r;
  logic        txie_r;
  logic        rxie_r;
  logic [10:0] addr_r;
  logic        sta_p_r;
  logic        stp_p_r;
  logic        rd_p_r;
  logic        nack_p_r;
  logic [7:0]  rxd_r;
  logic        nack_f_r;
  logic        sta_f_r;
  logic        stp_f_r;
  logic        busy_r;
  logic        txifg_r;
  logic        rxifg_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        scl_m_r, scl_s_r, scl_d_r;
  logic        sda_m_r, sda_s_r, sda_d_r;
  i2cp_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [8:0]  sh_r, sh_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic        stage_r, stage_nxt;
  logic        rdg_r, rdg_nxt;
  logic        scl_oe_r, scl_oe_nxt;
  logic        sda_oe_r, sda_oe_nxt;
  logic        take_sta, take_stp, take_rd, pop, rx_done, ack_in, nack_seen;

  i2cp_fifo_if #(.W(8)) txq ();

  i2cp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk   (CLK),
    .rst_b (RST_B),
    .f     (txq.store)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [31:0] wm      = sel_mask(WB_SEL_I);
  wire [31:0] wd      = WB_DAT_I & wm;
  wire        req     = WB_CYC_I & WB_STB_I & ~ack_r;
  wire        hit_ctl = (WB_ADR_I == OFS_CTRL);
  wire        hit_adr = (WB_ADR_I == OFS_ADDR);
  wire        hit_cmd = (WB_ADR_I == OFS_CMD);
  wire        hit_tx  = (WB_ADR_I == OFS_TXDATA);
  wire        hit_rx  = (WB_ADR_I == OFS_RXDATA);
  wire        hit_st  = (WB_ADR_I == OFS_STATUS);
  wire        tx_wr   = req & WB_WE_I & hit_tx & WB_SEL_I[0];
  // A full buffer stalls the bus answer rather than dropping the byte.
  wire        ack_nxt = req & (~tx_wr | txq.wr_ready);
  wire        wr      = ack_nxt & WB_WE_I;
  wire        rd      = ack_nxt & ~WB_WE_I;
  wire        ctl_wr  = wr & hit_ctl & WB_SEL_I[0];
  wire        cmd_wr  = wr & hit_cmd & WB_SEL_I[0];
  wire        st_w1c  = wr & hit_st;
  wire        rx_rd   = rd & hit_rx;

  assign txq.wr_valid = tx_wr;
  assign txq.wr_data  = WB_DAT_I[7:0];
  assign txq.rd_ready = pop;

  // The engine only runs released and in two-wire mode.
  wire run       = ~hold_r & (fsel_r == FSEL_TWO);
  wire tick      = (cnt_r == '0);
  wire dir_rd    = addr_r[ADDR_DIR];
  wire sta_seen  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stp_seen  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire [15:0] half = 16'(HALF_CYC - 1);

  // Read multiplexer.
  wire [31:0] ctl_v = {26'h0, rxie_r, txie_r, ten_r, fsel_r, hold_r};
  wire [31:0] cmd_v = {28'h0, nack_p_r, rd_p_r, stp_p_r, sta_p_r};
  wire [31:0] st_v  = {22'h0, rxifg_r, txifg_r, ~txq.wr_ready, 1'b0,
                       (st_r != S_IDLE), busy_r, 1'b0, stp_f_r, sta_f_r, nack_f_r};
  wire [31:0] rd_v  = hit_ctl ? ctl_v :
                      hit_adr ? {21'h0, addr_r} :
                      hit_cmd ? cmd_v :
                      hit_rx  ? {24'h0, rxd_r} :
                      hit_st  ? st_v : 32'h0;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // Two flops before anything looks at a line; the third is the edge history.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r} <= {SCL_I, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {SDA_I, sda_m_r, sda_s_r};
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------

  // Ack drops the cycle after it is given, so each access is answered once.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      if (rd) dat_r <= rd_v;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Power-up clear leaves the hold set; enables are zero while it stands.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      hold_r <= HOLD_RST;
      fsel_r <= FSEL_RST;
      ten_r  <= 1'b0;
      txie_r <= 1'b0;
      rxie_r <= 1'b0;
      addr_r <= 11'h0;
    end else begin
      if (ctl_wr) begin
        hold_r <= wd[CTRL_HOLD];
        fsel_r <= wd[CTRL_FSEL +: 2];
        ten_r  <= wd[CTRL_TEN];
      end
      if (hold_r | (ctl_wr & wd[CTRL_HOLD])) begin
        txie_r <= 1'b0;
        rxie_r <= 1'b0;
      end else if (ctl_wr) begin
        txie_r <= wd[CTRL_TXIE];
        rxie_r <= wd[CTRL_RXIE];
      end
      if (wr & hit_adr) addr_r <= (addr_r & ~wm[10:0]) | wd[10:0];
    end
  end

  // ----------------------------------------------------------------
  // Pending commands
  // ----------------------------------------------------------------

  // A new command written as the engine takes the old one stays pending.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      {nack_p_r, rd_p_r, stp_p_r, sta_p_r} <= 4'h0;
    end else begin
      sta_p_r <= (cmd_wr & wd[CMD_START]) | (sta_p_r & ~take_sta);
      stp_p_r <= (cmd_wr & wd[CMD_STOP]) | (stp_p_r & ~take_stp);
      rd_p_r  <= (cmd_wr & wd[CMD_READ]) | (rd_p_r & ~take_rd);
      if (cmd_wr & wd[CMD_READ]) nack_p_r <= wd[CMD_NACK];
    end
  end

  // ----------------------------------------------------------------
  // Status and flags
  // ----------------------------------------------------------------

  // Hardware sets win over software clears; the hold wipes bits 9, 8, 4, 2, 1 and 0.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      {nack_f_r, sta_f_r, stp_f_r, busy_r} <= 4'h0;
      txifg_r <= 1'b0;
      rxifg_r <= 1'b0;
      rxd_r   <= 8'h0;
    end else if (hold_r) begin
      {nack_f_r, sta_f_r, stp_f_r, busy_r} <= 4'h0;
      txifg_r <= 1'b0;
      rxifg_r <= 1'b0;
    end else begin
      nack_f_r <= nack_seen | (nack_f_r & ~(st_w1c & wd[ST_NACK]));
      sta_f_r  <= sta_seen | (sta_f_r & ~(st_w1c & wd[ST_STA_SEEN]));
      stp_f_r  <= stp_seen | (stp_f_r & ~(st_w1c & wd[ST_STP_SEEN]));
      busy_r   <= sta_seen | (busy_r & ~stp_seen);
      txifg_r  <= pop | (txifg_r & ~tx_wr & ~(st_w1c & wd[ST_TXIFG]));
      rxifg_r  <= rx_done | (rxifg_r & ~rx_rd & ~(st_w1c & wd[ST_RXIFG]));
      if (rx_done) rxd_r <= sh_nxt[8:1];
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------

  // Ack bit just clocked in on a written byte.
  assign ack_in    = sh_nxt[0];
  assign nack_seen = (st_r == S_B_HI) & (st_nxt == S_WAIT) & ~rdg_r & ack_in;

  // Next-state logic. SCL low counts a half period; SCL high starts counting
  // only once the line is seen high, so a stretching slave holds the engine.
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = tick ? cnt_r : cnt_r - 16'h1;
    sh_nxt     = sh_r;
    bit_nxt    = bit_r;
    stage_nxt  = stage_r;
    rdg_nxt    = rdg_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    take_sta   = 1'b0;
    take_stp   = 1'b0;
    take_rd    = 1'b0;
    pop        = 1'b0;
    rx_done    = 1'b0;
    if (!run) begin
      st_nxt     = S_IDLE;
      scl_oe_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          scl_oe_nxt = 1'b0;
          sda_oe_nxt = 1'b0;
          if (sta_p_r & ~busy_r) begin
            st_nxt     = S_STA;
            sda_oe_nxt = 1'b1;
            cnt_nxt    = half;
          end
        end
        S_STA: if (tick) begin
          take_sta   = 1'b1;
          scl_oe_nxt = 1'b1;
          sh_nxt     = {first_byte(ten_r, addr_r), 1'b1};
          stage_nxt  = ten_r & ~dir_rd;
          rdg_nxt    = 1'b0;
          bit_nxt    = 4'h0;
          st_nxt     = S_B_LO;
          cnt_nxt    = half;
        end
        S_B_LO: begin
          sda_oe_nxt = ~sh_r[8];
          if (tick) begin
            scl_oe_nxt = 1'b0;
            st_nxt     = S_B_HI;
            cnt_nxt    = half;
          end
        end
        S_B_HI: begin
          if (!scl_s_r) cnt_nxt = half;
          else if (tick) begin
            sh_nxt     = {sh_r[7:0], sda_s_r};
            scl_oe_nxt = 1'b1;
            cnt_nxt    = half;
            if (bit_r == 4'h8) begin
              bit_nxt = 4'h0;
              rx_done = rdg_r;
              st_nxt  = S_WAIT;
            end else begin
              bit_nxt = bit_r + 4'h1;
              st_nxt  = S_B_LO;
            end
          end
        end
        S_WAIT: begin
          bit_nxt = 4'h0;
          cnt_nxt = half;
          if (stage_r) begin
            sh_nxt    = {addr_r[7:0], 1'b1};
            stage_nxt = 1'b0;
            st_nxt    = S_B_LO;
          end else if (stp_p_r) begin
            take_stp = 1'b1;
            st_nxt   = S_P_LO;
          end else if (sta_p_r) begin
            st_nxt   = S_RS_LO;
          end else if (rd_p_r & dir_rd) begin
            take_rd = 1'b1;
            rdg_nxt = 1'b1;
            sh_nxt  = {8'hff, nack_p_r};
            st_nxt  = S_B_LO;
          end else if (txq.rd_valid & ~dir_rd) begin
            pop     = 1'b1;
            rdg_nxt = 1'b0;
            sh_nxt  = {txq.rd_data, 1'b1};
            st_nxt  = S_B_LO;
          end
        end
        S_RS_LO: begin
          sda_oe_nxt = 1'b0;
          if (tick) begin
            scl_oe_nxt = 1'b0;
            st_nxt     = S_RS_HI;
            cnt_nxt    = half;
          end
        end
        S_RS_HI: begin
          if (!scl_s_r) cnt_nxt = half;
          else if (tick) begin
            sda_oe_nxt = 1'b1;
            st_nxt     = S_STA;
            cnt_nxt    = half;
          end
        end
        S_P_LO: begin
          sda_oe_nxt = 1'b1;
          if (tick) begin
            scl_oe_nxt = 1'b0;
            st_nxt     = S_P_HI;
            cnt_nxt    = half;
          end
        end
        S_P_HI: begin
          if (!scl_s_r) cnt_nxt = half;
          else if (tick) begin
            sda_oe_nxt = 1'b0;
            st_nxt     = S_P_END;
            cnt_nxt    = half;
          end
        end
        S_P_END: if (tick) st_nxt = S_IDLE;
        default: begin
          st_nxt     = S_IDLE;
          scl_oe_nxt = 1'b0;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Engine registers.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_r     <= S_IDLE;
      cnt_r    <= 16'h0;
      sh_r     <= 9'h1ff;
      bit_r    <= 4'h0;
      stage_r  <= 1'b0;
      rdg_r    <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      bit_r    <= bit_nxt;
      stage_r  <= stage_nxt;
      rdg_r    <= rdg_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Lines are only ever pulled low, so the output data flops stay zero.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end
  end

  assign SCL_OE   = scl_oe_r;
  assign SDA_OE   = sda_oe_r;
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

endmodule : i2cp_core
`default_nettype wire

// File: test/i2cp_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Bus and line checks
// ------------------------------------------------------------
module i2cp_core_asserts
  import i2cp_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  // Line drivers.
  input wire logic        SCL_O,
  input wire logic        SCL_OE,
  input wire logic        SDA_O,
  input wire logic        SDA_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // An accepted control write; the new value counts from this edge.
  wire logic req     = WB_CYC_I && WB_STB_I;
  wire logic wr_ctrl = WB_ACK_O && WB_WE_I && WB_ADR_I == OFS_CTRL && WB_SEL_I[0];
  wire logic hold_wr = wr_ctrl && WB_DAT_I[CTRL_HOLD];
  // Both lines released by this block.
  wire logic quiet   = !SCL_OE && !SDA_OE;
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_next_cycle: assert property ($rose(req) && WB_ADR_I != OFS_TXDATA |=> WB_ACK_O)
    else $error("ack late");
  a_ack_has_cause: assert property (WB_ACK_O |-> $past(req))
    else $error("ack without request");
  a_pull_low_only: assert property (!SCL_O && !SDA_O)
    else $error("line driven high");
  a_hold_release: assert property (hold_wr |=> ##1 quiet [*3])
    else $error("lines driven under hold");
  a_mode_gate: assert property (wr_ctrl && WB_DAT_I[2:1] != FSEL_TWO |=> ##1 quiet [*3])
    else $error("lines driven outside two-wire mode");
  a_start_setup: assert property ($rose(SDA_OE) && !SCL_OE |=> !SCL_OE [*4])
    else $error("clock pulled too soon after start");
  a_stop_release: assert property ($fell(SDA_OE) && !SCL_OE |=> quiet [*2])
    else $error("line pulled right after stop");
  // Main scenarios: hold mid-transfer, start and stop.
  cover property (wr_ctrl && WB_DAT_I[CTRL_HOLD] && SCL_OE);
  cover property ($rose(SDA_OE) && !SCL_OE);
  cover property ($fell(SDA_OE) && !SCL_OE);
endmodule : i2cp_core_asserts
bind i2cp_core i2cp_core_asserts i_i2cp_core_asserts (.CLK, .RST_B, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O, .SCL_O, .SCL_OE, .SDA_O, .SDA_OE);
`default_nettype wire

// File: test/i2cp_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Far-side target device
// ------------------------------------------------------------
module i2cp_slave_model #(
  parameter logic [7:0] RD = 8'h3c
) (
  // Sensed line levels and pace.
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  // Pull-down enables.
  output var  logic sda_oe,
  output var  logic scl_oe
);
  logic       act = 1'b0;
  logic       first = 1'b0;
  logic       rdir = 1'b0;
  logic [7:0] sh = 8'h00;
  logic       nak = 1'b0;
  int         n = 0;
  // Both lines start released.
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  end
  // A data fall with the clock high opens a frame, also a restart.
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    first = 1'b1;
    nak = 1'b0;
    n = 0;
  end
  // A data rise with the clock high closes it.
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end
  // Bits are taken while the clock is high, first bit most significant.
  // A NACK on a read byte ends the target's turn, so the master can stop.
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8) nak = sda;
    n = n + 1;
  end
  // Data moves only after a clock fall, so it is steady while high.
  always @(negedge scl) if (act) begin
    if (n == 9) begin
      n = 0;
      if (first) rdir = sh[0];
      first = 1'b0;
    end
    sda_oe = (n == 8) ? !(rdir && !first) : (rdir && !first && !nak && !RD[7-n]);
    // A slow target stretches the low phase after each byte, with SDA already settled.
    if (slow && n == 0 && !first) begin
      scl_oe = 1'b1;
      #200 scl_oe = 1'b0;
    end
  end
endmodule : i2cp_slave_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Bench for the two-wire port
// ------------------------------------------------------------
module tb_top import i2cp_pkg::*;;
  typedef struct {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] e;
  } i2cp_row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        slow = 1'b1;
  logic [31:0] rdat;
  logic        ack;
  logic        scl_oe;
  logic        sda_oe;
  logic        m_scl_oe;
  logic        m_sda_oe;
  wire logic   scl_w = !(scl_oe || m_scl_oe);
  wire logic   sda_w = !(sda_oe || m_sda_oe);
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc_n = 0;
  int          bn = 0;
  logic        stopped = 1'b0;
  logic [8:0]  fr = 9'h0;
  logic [8:0]  q[$];
  logic [31:0] r;
  i2cp_row_t   rows[7] = '{'{1'b0, OFS_CTRL, 32'h0, 32'h1}, '{1'b0, OFS_STATUS, 32'h0, 32'h0},
    '{1'b1, OFS_CTRL, 32'h31, 32'h0}, '{1'b0, OFS_CTRL, 32'h0, 32'h1},
    '{1'b1, OFS_ADDR, 32'h50, 32'h0}, '{1'b0, OFS_ADDR, 32'h0, 32'h50},
    '{1'b0, 8'h20, 32'h0, 32'h0}};
  logic [8:0]  ef[9] = '{9'h140, 9'h022, 9'h044, 9'h066, 9'h088, 9'h142, 9'h079, 9'h1e8,
    9'h16a};
  i2cp_core #(.HALF_CYC(14)) i_i2cp_core (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCL_I(scl_w), .SCL_O(), .SCL_OE(scl_oe),
    .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe));
  i2cp_slave_model i_i2cp_slave_model (.scl(scl_w), .sda(sda_w), .slow(slow),
    .sda_oe(m_sda_oe), .scl_oe(m_scl_oe));
  always #2 clk = !clk;
  // A hang ends the run as a mismatch.
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // Wire monitor: nine clocks make one frame of byte and acknowledge.
  always @(negedge sda_w) if (scl_w) bn = 0;
  always @(posedge sda_w) if (scl_w) stopped = 1'b1;
  always @(posedge scl_w) begin
    fr = {fr[7:0], sda_w};
    bn++;
    if (bn == 9) begin
      q.push_back(fr);
      bn = 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    check_count++;
    if (got !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, e);
    end
  endtask : chk
  // One classic cycle; the request holds until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].wd);
      if (!rows[i].we) chk(r, rows[i].e);
    end
    // A pending START must stay idle while the mode is wrong.
    wb(1'b1, OFS_CTRL, 32'h0);
    wb(1'b1, OFS_CMD, 32'h1);
    repeat (80) @(posedge clk);
    chk(32'(q.size()), 32'h0);
    // Configure under hold and fill the buffer until full.
    wb(1'b1, OFS_CTRL, 32'h7);
    for (int i = 1; i < 5; i++) wb(1'b1, OFS_TXDATA, 32'h11 * i);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[ST_FULL]), 32'h1);
    wb(1'b1, OFS_CTRL, 32'h6);
    while (q.size() < 5) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[ST_BUSY]), 32'h1);
    // Restart to read one byte with NACK, then stop.
    wb(1'b1, OFS_ADDR, 32'h450);
    wb(1'b1, OFS_CMD, 32'hd);
    while (q.size() < 7) @(posedge clk);
    // The power-on rise of the lines looks like a stop; forget it here.
    stopped = 1'b0;
    wb(1'b1, OFS_CMD, 32'h2);
    while (!stopped) @(posedge clk);
    repeat (4) @(posedge clk);
    wb(1'b0, OFS_RXDATA, 32'h0);
    chk(r, 32'h3c);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[ST_BUSY]), 32'h0);
    chk(r & 32'h7, 32'h6);
    // Ten-bit target with a prompt far side.
    slow <= 1'b0;
    wb(1'b1, OFS_CTRL, 32'hf);
    wb(1'b1, OFS_ADDR, 32'h2b5);
    wb(1'b1, OFS_CTRL, 32'he);
    wb(1'b1, OFS_CMD, 32'h1);
    while (q.size() < 9) @(posedge clk);
    foreach (ef[i]) chk(32'(q[i]), 32'(ef[i]));
    // Hold while the clock is held low mid-transfer.
    repeat (40) @(posedge clk);
    wb(1'b1, OFS_CTRL, 32'hf);
    repeat (3) @(posedge clk);
    chk(32'({scl_oe, sda_oe}), 32'h0);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(r & 32'h37f, 32'h0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
